//--- hdl/nvmcl_engine.sv
// command execution engine: runs a fixed time and writes a result word
`timescale 1ns/1ps
`include "nvmcl_params.svh"
module nvmcl_engine (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // launch and parameters
  input wire logic start_i,
  input wire logic [15:0] word0_i,
  input wire logic [15:0] word1_i,
  // completion
  output logic done_o,
  output logic [15:0] result_o
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  // count the execution time, pulse done at the end
  always_comb begin
    run_nxt = run_r;
    cnt_nxt = cnt_r;
    done_o = 1'b0;
    if (start_i) begin
      run_nxt = 1'b1;
      cnt_nxt = `NVMCL_EXEC_CYCLES;
    end else if (run_r) begin
      if (cnt_r == 8'h01) begin
        run_nxt = 1'b0;
        done_o = 1'b1;
      end
      cnt_nxt = cnt_r - 8'h01;
    end
  end
  // register the counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end
  // result: simple checksum of command and address words
  assign result_o = word0_i ^ word1_i;
endmodule // nvmcl_engine

//--- hdl/nvmcl_params.svh
// constants for the nvm command launch interface
`ifndef NVMCL_PARAMS_SVH
`define NVMCL_PARAMS_SVH
`define NVMCL_OFF_INDEX 12'h000
`define NVMCL_OFF_DATA 12'h004
`define NVMCL_OFF_STATUS 12'h008
`define NVMCL_OFF_IRQ_STAT 12'h00C
`define NVMCL_OFF_IRQ_MASK 12'h010
`define NVMCL_OFF_EXEC 12'h014
`define NVMCL_IDX_W 3
`define NVMCL_WORDS 8
`define NVMCL_IDX_CMD 3'h0
`define NVMCL_IDX_ADDR 3'h1
`define NVMCL_IDX_DATA0 3'h2
`define NVMCL_IDX_HOLE0 3'h6
`define NVMCL_IDX_HOLE1 3'h7
`define NVMCL_BIT_CCF 7
`define NVMCL_BIT_BUSY 3
`define NVMCL_EXEC_CYCLES 8'h10
`define NVMCL_RESP_OKAY 2'h0
`define NVMCL_RESP_SLVERR 2'h2
`endif

//--- hdl/nvmcl_pkg.sv
// types for the nvm command launch interface
package nvmcl_pkg;
  typedef enum logic [1:0] {
    NVMCL_IDLE = 2'h0,
    NVMCL_LOCK = 2'h1,
    NVMCL_EXEC = 2'h3
  } nvmcl_state_t;
endpackage

//--- hdl/nvmcl_sticky.sv
// one sticky interrupt status bit with write-one-to-clear
`timescale 1ns/1ps
module nvmcl_sticky (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // event and clear
  input wire logic set_i,
  input wire logic clr_i,
  // state
  output logic flag_o
);
  logic flag_r;
  logic flag_nxt;
  // set wins over clear
  always_comb begin
    flag_nxt = set_i | (flag_r & ~clr_i);
  end
  // register the flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag_o = flag_r;
endmodule // nvmcl_sticky

//--- hdl/nvmcl_top.sv
// register front end for launching nvm commands over axi4-lite
`timescale 1ns/1ps
`include "nvmcl_params.svh"
// Operation
// - writing 1 to the complete flag clears it and starts the command.
// - while the complete flag is 0, parameter writes are ignored.
// - results written into the array are readable after the flag returns to 1.
// - indices 110 and 111 ignore writes and read 0x0000.
// - index 000 high byte carries the 8-bit command code.
// - index 000 low byte: six zero bits then address bits 17:16.
// - index 001 holds address 15:0; index 010 holds data word 0.
// - index register exposes three bits; others read zero.
// - busy flag is high while a command runs, low when idle.
module nvmcl_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // status
  output logic busy,
  output logic irq
);
  import nvmcl_pkg::*;

  logic [15:0] param_r [0:`NVMCL_WORDS-1];
  logic [15:0] param_nxt [0:`NVMCL_WORDS-1];
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic ccf_r;
  logic ccf_nxt;
  nvmcl_state_t st_r;
  nvmcl_state_t st_nxt;
  logic [1:0] mask_r;
  logic [1:0] mask_nxt;
  logic busy_r;
  logic irq_r;
  logic awready_r;
  logic awready_nxt;
  logic wready_r;
  logic wready_nxt;
  logic arready_r;
  logic arready_nxt;
  logic aw_hold_r;
  logic aw_hold_nxt;
  logic w_hold_r;
  logic w_hold_nxt;
  logic [11:0] awaddr_r;
  logic [11:0] awaddr_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0] wstrb_r;
  logic [3:0] wstrb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic wr_go;
  logic rd_go;
  logic launch;
  logic eng_done;
  logic [15:0] eng_result;
  logic [1:0] irq_stat;
  logic [1:0] irq_clr;
  logic [15:0] sel_word;

  // write channel acceptance, either order
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_arready = arready_r;
  assign wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
  assign rd_go = s_axi_arvalid & ~rvalid_r;

  // launch when complete flag is set and software writes 1 to it
  assign launch = wr_go & (awaddr_r == `NVMCL_OFF_STATUS) & wstrb_r[0]
    & wdata_r[`NVMCL_BIT_CCF] & ccf_r;

  // sticky events: bit0 command done, bit1 write refused while locked
  assign irq_clr = (wr_go & (awaddr_r == `NVMCL_OFF_IRQ_STAT) & wstrb_r[0]) ?
    wdata_r[1:0] : 2'h0;

  nvmcl_sticky u_done_flag (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set_i(eng_done),
    .clr_i(irq_clr[0]),
    .flag_o(irq_stat[0])
  );

  nvmcl_sticky u_lock_flag (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set_i(wr_go & ~ccf_r & (awaddr_r == `NVMCL_OFF_DATA)),
    .clr_i(irq_clr[1]),
    .flag_o(irq_stat[1])
  );

  nvmcl_engine u_engine (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start_i(st_r == NVMCL_LOCK),
    .word0_i(param_r[`NVMCL_IDX_CMD]),
    .word1_i(param_r[`NVMCL_IDX_ADDR]),
    .done_o(eng_done),
    .result_o(eng_result)
  );

  // word selected by index, holes read zero
  always_comb begin
    sel_word = param_r[idx_r];
    if (idx_r == `NVMCL_IDX_HOLE0 || idx_r == `NVMCL_IDX_HOLE1) begin
      sel_word = 16'h0000;
    end
  end

  // bus front end: capture, decode, answer
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      case (awaddr_r)
        `NVMCL_OFF_INDEX, `NVMCL_OFF_DATA, `NVMCL_OFF_STATUS,
        `NVMCL_OFF_IRQ_STAT, `NVMCL_OFF_IRQ_MASK: bresp_nxt = `NVMCL_RESP_OKAY;
        default: bresp_nxt = `NVMCL_RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `NVMCL_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case (s_axi_araddr)
        `NVMCL_OFF_INDEX: rdata_nxt = {29'h0, idx_r};
        `NVMCL_OFF_DATA: rdata_nxt = ccf_r ? {16'h0, sel_word} : 32'h0;
        `NVMCL_OFF_STATUS: begin
          rdata_nxt[`NVMCL_BIT_CCF] = ccf_r;
          rdata_nxt[`NVMCL_BIT_BUSY] = ~ccf_r;
        end
        `NVMCL_OFF_IRQ_STAT: rdata_nxt = {30'h0, irq_stat};
        `NVMCL_OFF_IRQ_MASK: rdata_nxt = {30'h0, mask_r};
        default: rresp_nxt = `NVMCL_RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    awready_nxt = ~aw_hold_nxt & ~bvalid_nxt; // ready lines leave flops
    wready_nxt = ~w_hold_nxt & ~bvalid_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  // registers: index, mask, parameter array, complete flag, launch state
  always_comb begin
    idx_nxt = idx_r;
    mask_nxt = mask_r;
    ccf_nxt = ccf_r;
    st_nxt = st_r;
    for (int i = 0; i < `NVMCL_WORDS; i++) begin
      param_nxt[i] = param_r[i];
    end
    if (wr_go && awaddr_r == `NVMCL_OFF_INDEX && wstrb_r[0]) begin
      idx_nxt = wdata_r[2:0];
    end
    if (wr_go && awaddr_r == `NVMCL_OFF_IRQ_MASK && wstrb_r[0]) begin
      mask_nxt = wdata_r[1:0];
    end
    // parameter writes only while idle and not in the holes
    if (wr_go && awaddr_r == `NVMCL_OFF_DATA && ccf_r
        && idx_r != `NVMCL_IDX_HOLE0 && idx_r != `NVMCL_IDX_HOLE1) begin
      if (wstrb_r[1]) begin
        param_nxt[idx_r][15:8] = wdata_r[15:8];
      end
      if (wstrb_r[0]) begin
        param_nxt[idx_r][7:0] = wdata_r[7:0];
      end
      if (idx_r == `NVMCL_IDX_CMD) begin
        param_nxt[idx_r][7:2] = 6'h00;
      end
    end
    case (st_r)
      NVMCL_IDLE: begin
        if (launch) begin
          ccf_nxt = 1'b0;
          st_nxt = NVMCL_LOCK;
        end
      end
      NVMCL_LOCK: st_nxt = NVMCL_EXEC;
      NVMCL_EXEC: begin
        if (eng_done) begin
          ccf_nxt = 1'b1;
          st_nxt = NVMCL_IDLE;
          param_nxt[`NVMCL_IDX_DATA0] = eng_result;
        end
      end
      default: st_nxt = NVMCL_IDLE;
    endcase
  end

  // register everything
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
      idx_r <= 3'h0;
      mask_r <= 2'h0;
      ccf_r <= 1'b1;
      st_r <= NVMCL_IDLE;
      busy_r <= 1'b0;
      irq_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      for (int i = 0; i < `NVMCL_WORDS; i++) begin
        param_r[i] <= 16'h0000;
      end
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      idx_r <= idx_nxt;
      mask_r <= mask_nxt;
      ccf_r <= ccf_nxt;
      st_r <= st_nxt;
      busy_r <= ~ccf_nxt;
      irq_r <= |(irq_stat & mask_r);
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      for (int i = 0; i < `NVMCL_WORDS; i++) begin
        param_r[i] <= param_nxt[i];
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign busy = busy_r;
  assign irq = irq_r;

  // checks
  sequence s_launch;
    launch;
  endsequence
  sequence s_flag_low;
    !ccf_r ##1 !ccf_r;
  endsequence

  a_launch_clears_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_launch |=> s_flag_low) else $error("complete flag not cleared on launch");
  a_param_locked: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!ccf_r && $past(!ccf_r)) |-> $stable({param_r[0], param_r[1], param_r[2],
    param_r[3], param_r[4], param_r[5]}))
    else $error("parameter changed while locked");
  a_hole_reads_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd_go && s_axi_araddr == `NVMCL_OFF_DATA && idx_r[2:1] == 2'h3)
    |=> rdata_r[15:0] == 16'h0000) else $error("hole read not zero");
  a_cmd_low_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    param_r[0][7:2] == 6'h00) else $error("command word bits not zero");
  a_index_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd_go && s_axi_araddr == `NVMCL_OFF_INDEX) |=> rdata_r[31:3] == 29'h0)
    else $error("index upper bits not zero");
  a_busy_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
    busy_r == ~ccf_r && busy_r == (st_r != NVMCL_IDLE)) else $error("busy does not track flag");
  a_flag_returns: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_launch |-> ##[2:20] ccf_r) else $error("command did not complete");
  a_result_stored: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_r == NVMCL_EXEC && eng_done) |=> (ccf_r && param_r[2] == $past(eng_result)))
    else $error("result not stored at completion");
  a_window_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd_go && s_axi_araddr == `NVMCL_OFF_DATA && ccf_r && idx_r == 3'h1)
    |=> rdata_r[15:0] == $past(param_r[1])) else $error("window read wrong");
endmodule // nvmcl_top

//--- test/tb.sv
// self-checking testbench for the nvm command launch front end
`timescale 1ns/1ps
`include "nvmcl_params.svh"
module tb;
  // one table row: write or read, address, strobes, data or expected data, response
  typedef struct {
    bit wr;
    logic [11:0] addr;
    logic [3:0] strb;
    logic [31:0] data;
    logic [1:0] resp;
  } nvmcl_tb_row_t;
  logic core_clk;
  logic arst_n;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic busy;
  logic irq;
  int err_count;
  int check_count;
  int cyc;
  logic [31:0] rd;
  logic [1:0] rs;
  localparam logic [1:0] OK = `NVMCL_RESP_OKAY;
  localparam logic [1:0] SE = `NVMCL_RESP_SLVERR;
  // ordinary cases, run in order
  nvmcl_tb_row_t rows [0:21] = '{
    '{0, 12'h000, 4'hF, 32'h0000_0000, OK},
    '{0, 12'h008, 4'hF, 32'h0000_0080, OK},
    '{0, 12'h010, 4'hF, 32'h0000_0000, OK},
    '{1, 12'h000, 4'hF, 32'hFFFF_FFFF, OK},
    '{0, 12'h000, 4'hF, 32'h0000_0007, OK},
    '{1, 12'h004, 4'h3, 32'h0000_FFFF, OK},
    '{0, 12'h004, 4'hF, 32'h0000_0000, OK},
    '{1, 12'h000, 4'hF, 32'h0000_0006, OK},
    '{1, 12'h004, 4'h3, 32'h0000_FFFF, OK},
    '{0, 12'h004, 4'hF, 32'h0000_0000, OK},
    '{1, 12'h020, 4'hF, 32'h0000_0001, SE},
    '{0, 12'h020, 4'hF, 32'h0000_0000, SE},
    '{1, 12'h000, 4'hF, 32'h0000_0000, OK},
    '{1, 12'h004, 4'h3, 32'h0000_12FF, OK},
    '{0, 12'h004, 4'hF, 32'h0000_1203, OK},
    '{1, 12'h000, 4'hF, 32'h0000_0001, OK},
    '{1, 12'h004, 4'h3, 32'h0000_ABCD, OK},
    '{1, 12'h004, 4'h1, 32'h0000_0011, OK},
    '{0, 12'h004, 4'hF, 32'h0000_AB11, OK},
    '{1, 12'h008, 4'h1, 32'h0000_0000, OK},
    '{0, 12'h008, 4'hF, 32'h0000_0080, OK},
    '{1, 12'h000, 4'hF, 32'h0000_0001, OK}
  };
  nvmcl_top nvmcl_top_inst (
    .core_clk(core_clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .busy(busy), .irq(irq)
  );
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_of_test();
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one axi4-lite write; address and data released each when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // one axi4-lite read
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // read and compare data and response
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_rd(a, rd, rs);
    chk(rd, exp, "read data");
    chk({30'h0, rs}, {30'h0, er}, "read response");
  endtask
  // wait for the running command to finish, bounded
  task automatic wait_idle();
    for (int n = 0; n < 200 && busy !== 1'b0; n++) begin
      @(posedge core_clk);
    end
  endtask
  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    err_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    // table of register cases
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].addr, rows[i].data, rows[i].strb, rs);
        chk({30'h0, rs}, {30'h0, rows[i].resp}, "write response");
      end else begin
        rd_chk(rows[i].addr, rows[i].data, rows[i].resp);
      end
    end
    $display("table test done");
    // launch, locked write, result readback
    axi_wr(12'h008, 32'h80, 4'h1, rs);
    chk({31'h0, busy}, 32'h1, "busy after launch");
    rd_chk(12'h008, 32'h08, OK);
    axi_wr(12'h004, 32'hFFFF, 4'h3, rs);
    rd_chk(12'h004, 32'h0, OK);
    wait_idle();
    chk({31'h0, busy}, 32'h0, "busy after completion");
    rd_chk(12'h008, 32'h80, OK);
    rd_chk(12'h004, 32'h0000_AB11, OK);
    axi_wr(12'h000, 32'h2, 4'hF, rs);
    rd_chk(12'h004, 32'h0000_B912, OK);
    $display("launch test done");
    // interrupt raise, mask and clear
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd_chk(12'h00C, 32'h3, OK);
    axi_wr(12'h010, 32'h3, 4'hF, rs);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    axi_wr(12'h00C, 32'h1, 4'hF, rs);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq one left");
    axi_wr(12'h00C, 32'h2, 4'hF, rs);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd_chk(12'h00C, 32'h0, OK);
    $display("interrupt test done");
    // reset in the middle of a command
    axi_wr(12'h008, 32'h80, 4'h1, rs);
    chk({31'h0, busy}, 32'h1, "busy before reset");
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    chk({31'h0, busy}, 32'h0, "busy in reset");
    rd_chk(12'h008, 32'h80, OK);
    rd_chk(12'h000, 32'h0, OK);
    $display("reset test done");
    end_of_test();
  end
endmodule // tb
